// ===== logic/timer_pkg.sv
// Constants for the main free-running timer and the periodic tick source.
// Assumes one bus clock; the write window figure below is counted in bus cycles.
package timer_pkg;

	// Register byte addresses.
	localparam logic [15:0] TIMER_MASK_TWO_ADDR   = 16'h1024;
	localparam logic [15:0] TIMER_FLAGS_TWO_ADDR  = 16'h1025;
	localparam logic [15:0] RATE_CONTROL_ADDR     = 16'h1026;
	localparam logic [15:0] TEST_CONTROL_ADDR     = 16'h103E;
	localparam logic [15:0] COUNT_HIGH_ADDR       = 16'h100E;
	localparam logic [15:0] COUNT_LOW_ADDR        = 16'h100F;

	// Field positions.
	localparam int WRAP_BIT        = 7;
	localparam int TICK_BIT        = 6;
	localparam int PRESCALE_HI_BIT = 1;
	localparam int PRESCALE_LO_BIT = 0;
	localparam int RATE_HI_BIT     = 1;
	localparam int RATE_LO_BIT     = 0;
	localparam int BYPASS_BIT      = 2;

	// Prescaler select codes.
	localparam logic [1:0] PRESCALE_DIV1  = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
	localparam logic [1:0] PRESCALE_DIV8  = 2'h2;
	localparam logic [1:0] PRESCALE_DIV16 = 2'h3;

	// Reset values.
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [1:0]  PRESCALE_RESET = PRESCALE_DIV1;
	localparam logic [1:0]  RATE_RESET     = 2'h0;

	// Timing counts.
	localparam logic [6:0] WRITE_WINDOW_CYCLES = 7'h40;
	localparam int         TICK_DIV_BITS       = 13;

endpackage

// ===== logic/tick_if.sv
// Carries the rate select, clock enable and tick pulse between the timer and its tick source.
// Assumes both ends share the single bus clock.
`timescale 1ns/1ns
interface tick_if;
	logic [1:0] rate_sel;
	logic       ce;
	logic       tick;

	modport gen (input rate_sel, input ce, output tick);
	modport user (output rate_sel, output ce, input tick);
endinterface

// ===== logic/periodic_tick_gen.sv
// Free-running divider that produces the periodic tick pulse.
// Assumes synchronous active-low reset and the clock enable carried in the interface.
`timescale 1ns/1ns
module periodic_tick_gen
	import timer_pkg::*;
#(
	parameter int DIV_BITS = TICK_DIV_BITS
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	tick_if.gen       link
);
	localparam int CW = DIV_BITS + 3;

	typedef struct packed {
		logic [CW-1:0] div;
		logic          tick;
	} tick_state_s;

	tick_state_s s_reg;
	tick_state_s s_next;
	logic [CW-1:0] mask;

	// The divider never resets mid-run, so the period is measured from the previous tick only.
	always_comb begin
		s_next = s_reg;
		mask = {CW{1'b1}} >> (2'h3 - link.rate_sel);
		s_next.div = s_reg.div + 1'b1;
		s_next.tick = ((s_reg.div & mask) == mask);
	end

	// One register stage; a low clock enable freezes the divider.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (link.ce) begin
			s_reg <= s_next;
		end
	end

	assign link.tick = s_reg.tick;

	tick_spacing_a: assert property (@(posedge mclk) disable iff (!rst_n)
		link.ce && link.tick |=> !link.tick)
		else $error("Periodic tick lasted more than one enabled cycle.");

endmodule // periodic_tick_gen

// ===== logic/main_timer.sv
// Main 16-bit free-running timer with prescaler, wrap flag, counter bypass and periodic tick flag.
// Assumes a bus master with one-cycle strobes and read data expected one cycle later.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module main_timer
	import timer_pkg::*;
#(
	parameter int TICK_BITS = TICK_DIV_BITS
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        special_mode,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	output logic             irq,
	output logic      [15:0] count_value
);

	typedef struct packed {
		logic [15:0] count;
		logic [3:0]  pre;
		logic [6:0]  win_cnt;
		logic        pr_written;
		logic [1:0]  prescale;
		logic        wrap_irq_en;
		logic        tick_irq_en;
		logic        wrap_flag;
		logic        tick_flag;
		logic [1:0]  rate_sel;
		logic        bypass;
		logic [7:0]  rdata;
		logic        irq;
	} timer_state_s;

	timer_state_s s_reg;
	timer_state_s s_next;

	logic advance;
	logic wrap_event;
	logic window_open;
	logic wr_mask;
	logic wr_flags;
	logic wr_rate;
	logic wr_test;

	tick_if tick_link ();

	assign tick_link.rate_sel = s_reg.rate_sel;
	assign tick_link.ce = ce;

	// The tick divider is separate from the prescaler, so the tick rate ignores prescale select.
	periodic_tick_gen #(
		.DIV_BITS (TICK_BITS)
	) u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.link  (tick_link)
	);

	// Address decode for writes.
	assign wr_mask  = wr && (addr == TIMER_MASK_TWO_ADDR);
	assign wr_flags = wr && (addr == TIMER_FLAGS_TWO_ADDR);
	assign wr_rate  = wr && (addr == RATE_CONTROL_ADDR);
	assign wr_test  = wr && (addr == TEST_CONTROL_ADDR);
	assign window_open = (s_reg.win_cnt < WRITE_WINDOW_CYCLES);

	// Count enable from the prescaler taps; bypass clocks the whole counter every cycle.
	always_comb begin
		if (s_reg.bypass) begin
			advance = 1'b1;
		end else begin
			case (s_reg.prescale)
				PRESCALE_DIV1:  advance = 1'b1;
				PRESCALE_DIV4:  advance = (s_reg.pre[1:0] == 2'h3);
				PRESCALE_DIV8:  advance = (s_reg.pre[2:0] == 3'h7);
				PRESCALE_DIV16: advance = (s_reg.pre == 4'hF);
				default:        advance = 1'b1;
			endcase
		end
	end

	assign wrap_event = advance && (s_reg.count == 16'hFFFF);

	// Next-state logic for counter, control bits, flags, read data and interrupt.
	always_comb begin
		s_next = s_reg;

		// Prescaler and counter run freely; nothing software writes stops them.
		s_next.pre = s_reg.pre + 4'h1;
		if (advance) begin
			s_next.count = s_reg.count + 16'h0001;
		end

		// The write window counts bus cycles after reset and then saturates.
		if (window_open) begin
			s_next.win_cnt = s_reg.win_cnt + 7'h01;
		end

		// Interrupt enables are always writable; the prescale field is time-protected outside special mode.
		if (wr_mask) begin
			s_next.wrap_irq_en = wdata[WRAP_BIT];
			s_next.tick_irq_en = wdata[TICK_BIT];
			if (special_mode || (window_open && !s_reg.pr_written)) begin
				s_next.prescale = {wdata[PRESCALE_HI_BIT], wdata[PRESCALE_LO_BIT]};
				s_next.pr_written = 1'b1;
			end
		end

		// Rate select has no protection window.
		if (wr_rate) begin
			s_next.rate_sel = {wdata[RATE_HI_BIT], wdata[RATE_LO_BIT]};
		end

		// Bypass is reachable only in special modes, so normal timing cannot be corrupted.
		if (wr_test && special_mode) begin
			s_next.bypass = wdata[BYPASS_BIT];
		end

		// Clear by writing one; a set in the same cycle wins over the clear.
		if (wr_flags && wdata[WRAP_BIT]) begin
			s_next.wrap_flag = 1'b0;
		end
		if (wr_flags && wdata[TICK_BIT]) begin
			s_next.tick_flag = 1'b0;
		end
		if (wrap_event) begin
			s_next.wrap_flag = 1'b1;
		end
		if (tick_link.tick) begin
			s_next.tick_flag = 1'b1;
		end

		// Read data is valid only in the cycle after the strobe.
		s_next.rdata = 8'h00;
		if (rd) begin
			case (addr)
				TIMER_MASK_TWO_ADDR: begin
					s_next.rdata[WRAP_BIT] = s_reg.wrap_irq_en;
					s_next.rdata[TICK_BIT] = s_reg.tick_irq_en;
					s_next.rdata[PRESCALE_HI_BIT] = s_reg.prescale[1];
					s_next.rdata[PRESCALE_LO_BIT] = s_reg.prescale[0];
				end
				TIMER_FLAGS_TWO_ADDR: begin
					s_next.rdata[WRAP_BIT] = s_reg.wrap_flag;
					s_next.rdata[TICK_BIT] = s_reg.tick_flag;
				end
				RATE_CONTROL_ADDR: begin
					s_next.rdata[RATE_HI_BIT] = s_reg.rate_sel[1];
					s_next.rdata[RATE_LO_BIT] = s_reg.rate_sel[0];
				end
				TEST_CONTROL_ADDR: s_next.rdata[BYPASS_BIT] = s_reg.bypass;
				COUNT_HIGH_ADDR:   s_next.rdata = s_reg.count[15:8];
				COUNT_LOW_ADDR:    s_next.rdata = s_reg.count[7:0];
				default:           s_next.rdata = 8'h00;
			endcase
		end

		// Level interrupt follows the flags, never the enables alone.
		s_next.irq = (s_next.wrap_flag && s_next.wrap_irq_en)
			|| (s_next.tick_flag && s_next.tick_irq_en);
	end

	// Single state register; reset is synchronous and a low clock enable freezes everything.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.count <= COUNT_RESET;
			s_reg.prescale <= PRESCALE_RESET;
			s_reg.rate_sel <= RATE_RESET;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign rdata = s_reg.rdata;
	assign irq = s_reg.irq;
	assign count_value = s_reg.count;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	wrap_flag_set_a: assert property (ce && wrap_event |=> s_reg.wrap_flag)
		else $error("Counter wrapped without setting the wrap flag.");

	wrap_flag_clear_a: assert property (
		ce && wr_flags && wdata[WRAP_BIT] && !wrap_event |=> !s_reg.wrap_flag)
		else $error("Wrap flag survived a clearing write.");

	flag_hold_a: assert property (
		ce && s_reg.wrap_flag && !(wr_flags && wdata[WRAP_BIT]) |=> s_reg.wrap_flag)
		else $error("Wrap flag cleared without a one written to it.");

	tick_flag_set_a: assert property (ce && tick_link.tick |=> s_reg.tick_flag)
		else $error("Periodic tick did not set the tick flag.");

	irq_gate_a: assert property (
		irq == ((s_reg.wrap_flag && s_reg.wrap_irq_en)
		|| (s_reg.tick_flag && s_reg.tick_irq_en)))
		else $error("Interrupt output disagrees with flags and enables.");

	prescale_lock_a: assert property (
		ce && wr_mask && !special_mode && (!window_open || s_reg.pr_written)
		|=> $stable(s_reg.prescale))
		else $error("Prescale select changed outside its write window.");

	// The sampled rst_n keeps the release edge out, since the design still resets there.
	div_one_count_a: assert property (
		rst_n && ce && !s_reg.bypass && (s_reg.prescale == PRESCALE_DIV1)
		|=> s_reg.count == $past(s_reg.count) + 16'h0001)
		else $error("Divide-by-one counter did not advance.");

	div_four_hold_a: assert property (
		ce && !s_reg.bypass && (s_reg.prescale == PRESCALE_DIV4)
		&& (s_reg.pre[1:0] != 2'h3) |=> $stable(s_reg.count))
		else $error("Divide-by-four counter advanced early.");

	bypass_guard_a: assert property (ce && wr_test && !special_mode |=> $stable(s_reg.bypass))
		else $error("Bypass bit changed outside special mode.");

	bypass_count_a: assert property (rst_n && ce && s_reg.bypass
		|=> s_reg.count == $past(s_reg.count) + 16'h0001)
		else $error("Bypassed counter did not advance every cycle.");

	// A low clock enable must hold every bit of state, strobes and ticks included.
	enable_freeze_a: assert property (rst_n && !ce |=> $stable(s_reg))
		else $error("Timer state changed while the clock enable was low.");

endmodule // main_timer

// ===== dv/main_timer_test.sv
// Testbench for the main timer: register access, count rates, wrap flag and tick flag.
// Assumes the timer package, the tick interface and the design modules are compiled first.
`timescale 1ns/1ns
module main_timer_test;
	import timer_pkg::*;
	localparam logic [15:0] MSK = TIMER_MASK_TWO_ADDR;
	localparam logic [15:0] FLG = TIMER_FLAGS_TWO_ADDR;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        ce = 1;
	logic        special_mode = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 0;
	logic        rd = 0;
	logic [7:0]  rdata;
	logic        irq;
	logic [15:0] count_value;
	logic [15:0] c0;
	logic [7:0]  v;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n;
	logic [15:0] per_code [4] = '{16'h0040, 16'h0010, 16'h0008, 16'h0004};

	// A six-bit tick divider (TICK_BITS of 3) keeps tick periods between 8 and 64 cycles.
	main_timer #(.TICK_BITS(3)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.special_mode(special_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .count_value(count_value));

	// Bus clock, 40 ns period.
	always #20 mclk = ~mclk;

	// The run needs one full counter wrap plus a few hundred cycles.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 99000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("%0d checks, %0d mismatches", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One-cycle write strobe, launched just after a rising edge.
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle there.
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd <= 1;
		addr <= a;
		@(posedge mclk);
		rd <= 0;
		@(negedge mclk);
		d = rdata;
	endtask

	// Counter advance over 64 cycles is exact for every divisor, whatever the prescaler phase.
	task automatic rate_chk(input logic [15:0] exp, input string what);
		@(negedge mclk);
		c0 = count_value;
		repeat (64) @(negedge mclk);
		check(count_value - c0, exp, what);
	endtask

	// Counts cycles until irq is seen low and then high again; bounded so a stuck line ends.
	task automatic wait_rise(output int k);
		logic last;
		last = irq;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
			if (irq === 1'b1 && last === 1'b0)
				break;
			last = irq;
		end while (k < 300);
	endtask

	task automatic reset_dut();
		rst_n <= 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		@(negedge mclk);
		check(count_value, 16'h0000, "count after reset");
		check({15'h0000, irq}, 16'h0000, "irq after reset");
		rd_reg(MSK, v);
		check({8'h00, v}, 16'h0000, "mask after reset");
		rd_reg(FLG, v);
		check({8'h00, v}, 16'h0000, "flags after reset");
		rd_reg(16'h1000, v);
		check({8'h00, v}, 16'h0000, "unmapped read");
	endtask

	// Main sequence: window, bypass, prescale codes, tick rates, then one counter wrap.
	initial begin
		reset_dut();
		repeat (70) @(posedge mclk);
		wr_reg(MSK, {6'h00, PRESCALE_DIV16});
		rate_chk(16'h0040, "late prescale write");
		reset_dut();
		wr_reg(MSK, {6'h00, PRESCALE_DIV16});
		rate_chk(16'h0004, "divide by 16");
		wr_reg(MSK, {6'h00, PRESCALE_DIV1});
		rd_reg(MSK, v);
		check({8'h00, v}, 16'h0003, "prescale kept");
		rate_chk(16'h0004, "second prescale write");
		wr_reg(TEST_CONTROL_ADDR, 8'h04);
		rd_reg(TEST_CONTROL_ADDR, v);
		check({8'h00, v}, 16'h0000, "bypass bit in normal mode");
		rate_chk(16'h0004, "bypass in normal mode");
		@(posedge mclk);
		special_mode <= 1;
		wr_reg(TEST_CONTROL_ADDR, 8'h04);
		rate_chk(16'h0040, "bypass count");
		wr_reg(TEST_CONTROL_ADDR, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr_reg(MSK, 8'(i));
			rate_chk(per_code[i], "prescale code");
		end
		$display("prescale test finished");
		// A tick on the clearing edge wins over the clear, so clear again until irq reads low.
		wr_reg(MSK, 8'h40);
		for (int r = 0; r < 4; r++) begin
			wr_reg(RATE_CONTROL_ADDR, 8'(r));
			do begin
				wr_reg(FLG, 8'h40);
				@(negedge mclk);
			end while (irq !== 1'b0);
			wait_rise(n);
			wr_reg(FLG, 8'h40);
			wait_rise(n);
			check(16'(n + 1), 16'h0008 << r, "tick period");
		end
		rd_reg(RATE_CONTROL_ADDR, v);
		check({8'h00, v}, 16'h0003, "rate select readback");
		wait_rise(n);
		repeat (150) @(negedge mclk);
		check({15'h0000, irq}, 16'h0001, "tick irq held");
		rd_reg(FLG, v);
		check({15'h0000, v[TICK_BIT]}, 16'h0001, "tick flag held");
		wr_reg(MSK, 8'h00);
		@(negedge mclk);
		check({15'h0000, irq}, 16'h0000, "tick irq masked");
		$display("tick test finished");
		n = 0;
		while (count_value !== 16'hFFFF && n < 70000) begin
			@(negedge mclk);
			n++;
		end
		repeat (2) @(negedge mclk);
		rd_reg(FLG, v);
		check({15'h0000, v[WRAP_BIT]}, 16'h0001, "wrap flag");
		check({15'h0000, irq}, 16'h0000, "wrap irq disabled");
		c0 = count_value;
		repeat (10) @(negedge mclk);
		check(count_value - c0, 16'h000A, "count after wrap");
		// The byte reads see the count one cycle before the data appear, at divide by one.
		rd_reg(COUNT_HIGH_ADDR, v);
		check({8'h00, v}, 16'h0000, "count high byte");
		rd_reg(COUNT_LOW_ADDR, v);
		check({8'h00, v}, {8'h00, count_value[7:0] - 8'h01}, "count low byte");
		// A low clock enable freezes the counter although the prescaler would advance it.
		@(posedge mclk);
		ce <= 1'b0;
		@(negedge mclk);
		c0 = count_value;
		repeat (20) @(negedge mclk);
		check(count_value, c0, "count frozen by enable");
		@(posedge mclk);
		ce <= 1'b1;
		wr_reg(MSK, 8'h80);
		@(negedge mclk);
		check({15'h0000, irq}, 16'h0001, "wrap irq enabled");
		wr_reg(FLG, 8'h40);
		rd_reg(FLG, v);
		check({15'h0000, v[WRAP_BIT]}, 16'h0001, "zero bit kept");
		wr_reg(FLG, 8'h80);
		@(negedge mclk);
		check({15'h0000, irq}, 16'h0000, "wrap cleared");
		$display("wrap test finished");
		summarize();
	end
endmodule // main_timer_test
